// >>> multi_mode_timer_counter.sv
// one timer/counter instance: timer, event counter, pwm, capture, delta-sigma
//
// Contract
// - timer base clock is the system clock, selected as 16 or 32 MHz rate.
// - 5-bit prescaler: zero passes clock, else divides by 2^setting, up to 16.
// - counter, rise and fall registers are 17 bits wide.
// - with gating on, counter holds while gate input high, counts while low.
// - match event when a count tick finds counter equal to rise or fall value, except in delta-sigma and capture modes.
// - pwm output goes high when counter equals rise value.
// - pwm output goes low at fall value; continuous mode restarts counter.
// - new rise/fall values take effect only after the running cycle ends.
// - pwm runs as single pulse or repeating train with programmed period.
// - waveform reaches the pin only while output driver enable is set.
// - capture stores count in rise register on first rising capture edge.
// - capture stores count in fall register on the following falling edge.
// - software read of a capture register stops the counter.
// - captures count from start; later edges overwrite, last pulse kept.
// - timer mode counts prescaled clock, single or repeating, matches at fall.
// - event counter counts gate-pin rising, falling or both edges.
// - event counting exists only on the first general-purpose timer.
// - nrz delta-sigma gives rise-value pulses per 2^17 clock period.
// - delta-sigma pulse pattern is pseudo-random and changes every period.
// - rtz delta-sigma forces every other slot low, period 2^18 clocks.
// - pwm-only kind has no counter mode, no capture, no gating.
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps

module multi_mode_timer_counter #(
	parameter logic [1:0] KIND = mmtc_pkg::KIND_TIMER_A
) (
	// clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_rstn,
	// register port
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	// pins
	input  wire logic        i_timer_a_clock_gate_input,
	input  wire logic        i_capture_input,
	output logic             o_wave_output,
	output logic             o_wave_output_oe,
	// match events
	output logic             o_rise_match,
	output logic             o_fall_match
);

	typedef enum logic {CAP_WAIT_RISE, CAP_WAIT_FALL} cap_state_t;

	localparam bit HAS_EVENT   = (KIND == mmtc_pkg::KIND_TIMER_A);
	localparam bit HAS_CAPTURE = (KIND != mmtc_pkg::KIND_PWM);
	localparam bit HAS_GATE    = (KIND != mmtc_pkg::KIND_PWM);

	// control state
	logic [2:0]  mode_r;
	logic [1:0]  edge_r;
	logic [4:0]  presc_r;
	logic        single_r, gate_en_r, oe_r, clk32_r, running_r;

	// counting state
	logic [16:0] cnt_r, rise_r, fall_r, rise_act_r, fall_act_r, scramble_r;
	logic        wave_r, half_r, rtz_phase_r, flag_rise_r, flag_fall_r;
	logic [15:0] div_r;
	cap_state_t  cap_state_r;
	logic [31:0] rdata_r;

	// synchronisers
	logic        gate_s1_r, gate_s2_r, gate_s3_r;
	logic        cap_s1_r, cap_s2_r, cap_s3_r;

	// decoded controls
	logic        wr_ctrl, start_pulse, stop_req, is_counter, is_capture, is_pwm, is_ds, is_rtz, gate_hold;
	logic        base_tick, presc_tick, ev_rise, ev_fall, ev_tick, cnt_tick, hit_rise, hit_fall, cycle_end;
	logic        ds_adv, ds_period_end, ds_hit, cap_rise_store, cap_fall_store, cap_read;
	logic [15:0] presc_mask;
	logic [16:0] rev_cnt;
	logic [2:0]  mode_wr;

	assign wr_ctrl     = i_wr && (i_addr == mmtc_pkg::OFF_CTRL);
	assign start_pulse = wr_ctrl && i_wdata[mmtc_pkg::CTRL_START_BIT];
	assign stop_req    = wr_ctrl && !i_wdata[mmtc_pkg::CTRL_START_BIT];

	// unsupported modes for this kind fall back to plain timer
	always_comb begin
		mode_wr = i_wdata[mmtc_pkg::CTRL_MODE_LSB +: 3];
		if ((mode_wr == mmtc_pkg::MODE_COUNTER && !HAS_EVENT)
			|| (mode_wr == mmtc_pkg::MODE_CAPTURE && !HAS_CAPTURE)
			|| (mode_wr > mmtc_pkg::MODE_DS_RTZ)) begin
			mode_wr = mmtc_pkg::MODE_TIMER;
		end
	end

	assign is_counter = (mode_r == mmtc_pkg::MODE_COUNTER);
	assign is_capture = (mode_r == mmtc_pkg::MODE_CAPTURE);
	assign is_pwm     = (mode_r == mmtc_pkg::MODE_PWM);
	assign is_rtz     = (mode_r == mmtc_pkg::MODE_DS_RTZ);
	assign is_ds      = (mode_r == mmtc_pkg::MODE_DS_NRZ) || is_rtz;

	// control register
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			mode_r    <= mmtc_pkg::MODE_TIMER;
			single_r  <= 1'b0;
			gate_en_r <= 1'b0;
			edge_r    <= mmtc_pkg::EDGE_RISE;
			oe_r      <= 1'b0;
			clk32_r   <= 1'b0;
		end else if (wr_ctrl) begin
			mode_r    <= mode_wr;
			single_r  <= i_wdata[mmtc_pkg::CTRL_SINGLE_BIT];
			gate_en_r <= i_wdata[mmtc_pkg::CTRL_GATE_BIT] && HAS_GATE;
			edge_r    <= i_wdata[mmtc_pkg::CTRL_EDGE_LSB +: 2];
			oe_r      <= i_wdata[mmtc_pkg::CTRL_OE_BIT];
			clk32_r   <= i_wdata[mmtc_pkg::CTRL_CLK32_BIT];
		end
	end

	// prescale register, settings above 16 are clamped
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			presc_r <= 5'h00;
		end else if (i_wr && i_addr == mmtc_pkg::OFF_PRESC) begin
			presc_r <= (i_wdata[4:0] > mmtc_pkg::PRESC_MAX) ? mmtc_pkg::PRESC_MAX : i_wdata[4:0];
		end
	end

	// pin synchronisers plus one stage for edge detection
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			gate_s1_r <= 1'b0;
			gate_s2_r <= 1'b0;
			gate_s3_r <= 1'b0;
			cap_s1_r  <= 1'b0;
			cap_s2_r  <= 1'b0;
			cap_s3_r  <= 1'b0;
		end else begin
			gate_s1_r <= i_timer_a_clock_gate_input;
			gate_s2_r <= gate_s1_r;
			gate_s3_r <= gate_s2_r;
			cap_s1_r  <= i_capture_input;
			cap_s2_r  <= cap_s1_r;
			cap_s3_r  <= cap_s2_r;
		end
	end

	// base rate: 32 MHz selection ticks every clock, 16 MHz every other clock
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			half_r <= 1'b0;
		end else begin
			half_r <= !half_r;
		end
	end
	assign base_tick = clk32_r || half_r;
	// free-running prescaler divider
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			div_r <= 16'h0000;
		end else if (base_tick) begin
			div_r <= div_r + 16'h0001;
		end
	end

	assign presc_mask = 16'((17'h00001 << presc_r) - 17'h00001);
	assign presc_tick = base_tick && ((div_r & presc_mask) == presc_mask);

	// event edges from the gate pin
	assign ev_rise = gate_s2_r && !gate_s3_r;
	assign ev_fall = !gate_s2_r && gate_s3_r;
	always_comb begin
		case (edge_r)
			mmtc_pkg::EDGE_RISE: ev_tick = ev_rise;
			mmtc_pkg::EDGE_FALL: ev_tick = ev_fall;
			mmtc_pkg::EDGE_BOTH: ev_tick = ev_rise || ev_fall;
			default:             ev_tick = 1'b0;
		endcase
	end
	assign gate_hold = gate_en_r && gate_s2_r;
	assign cnt_tick  = running_r && (is_counter ? ev_tick : (presc_tick && !gate_hold));

	// compare matches on the active copies
	assign hit_rise  = (cnt_r == rise_act_r);
	assign hit_fall  = (cnt_r == fall_act_r);
	assign cycle_end = cnt_tick && !is_capture && !is_ds && hit_fall;

	// delta-sigma: bit-reversed count scrambled per period
	genvar gi;
	generate
		for (gi = 0; gi < 17; gi = gi + 1) begin : g_rev
			assign rev_cnt[gi] = cnt_r[16 - gi];
		end
	endgenerate

	assign ds_hit        = ((rev_cnt ^ scramble_r) < rise_act_r);
	assign ds_adv        = cnt_tick && is_ds && (!is_rtz || rtz_phase_r);
	assign ds_period_end = ds_adv && (cnt_r == mmtc_pkg::CNT_TOP);

	// capture edge handling
	assign cap_rise_store = running_r && is_capture && (cap_state_r == CAP_WAIT_RISE) && cap_s2_r && !cap_s3_r;
	assign cap_fall_store = running_r && is_capture && (cap_state_r == CAP_WAIT_FALL) && !cap_s2_r && cap_s3_r;
	assign cap_read       = i_rd && is_capture && (i_addr == mmtc_pkg::OFF_RISE || i_addr == mmtc_pkg::OFF_FALL);

	// run control
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			running_r <= 1'b0;
		end else if (start_pulse) begin
			running_r <= 1'b1;
		end else if (stop_req || cap_read) begin
			running_r <= 1'b0;
		end else if (cycle_end && single_r) begin
			running_r <= 1'b0;
		end
	end

	// counter
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_r <= mmtc_pkg::CNT_RESET;
		end else if (start_pulse) begin
			cnt_r <= mmtc_pkg::CNT_RESET;
		end else if (is_ds) begin
			if (ds_adv) begin
				cnt_r <= cnt_r + 17'h00001;
			end
		end else if (cycle_end) begin
			cnt_r <= mmtc_pkg::CNT_RESET;
		end else if (cnt_tick) begin
			cnt_r <= cnt_r + 17'h00001;
		end
	end

	// rtz slot phase
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			rtz_phase_r <= 1'b0;
		end else if (start_pulse) begin
			rtz_phase_r <= 1'b0;
		end else if (cnt_tick && is_rtz) begin
			rtz_phase_r <= !rtz_phase_r;
		end
	end

	// scrambler advances once per conversion period
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			scramble_r <= mmtc_pkg::LFSR_SEED;
		end else if (ds_period_end) begin
			scramble_r <= {scramble_r[15:0], scramble_r[16] ^ scramble_r[13]};
		end
	end

	// active compare copies load at start and at cycle or period end
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			rise_act_r <= mmtc_pkg::CNT_RESET;
			fall_act_r <= mmtc_pkg::CNT_RESET;
		end else if (start_pulse || cycle_end || ds_period_end) begin
			rise_act_r <= rise_r;
			fall_act_r <= fall_r;
		end
	end

	// rise register: software write or capture
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			rise_r <= mmtc_pkg::CNT_RESET;
		end else if (cap_rise_store) begin
			rise_r <= cnt_r;
		end else if (i_wr && i_addr == mmtc_pkg::OFF_RISE) begin
			rise_r <= i_wdata[16:0];
		end
	end

	// fall register: software write or capture
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			fall_r <= mmtc_pkg::CNT_RESET;
		end else if (cap_fall_store) begin
			fall_r <= cnt_r;
		end else if (i_wr && i_addr == mmtc_pkg::OFF_FALL) begin
			fall_r <= i_wdata[16:0];
		end
	end

	// capture sequencer, rearms after each falling capture
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			cap_state_r <= CAP_WAIT_RISE;
		end else if (start_pulse) begin
			cap_state_r <= CAP_WAIT_RISE;
		end else begin
			case (cap_state_r)
				CAP_WAIT_RISE: begin
					if (cap_rise_store) begin
						cap_state_r <= CAP_WAIT_FALL;
					end
				end
				CAP_WAIT_FALL: begin
					if (cap_fall_store) begin
						cap_state_r <= CAP_WAIT_RISE;
					end
				end
				default: cap_state_r <= CAP_WAIT_RISE;
			endcase
		end
	end

	// waveform
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			wave_r <= 1'b0;
		end else if (start_pulse || stop_req) begin
			wave_r <= 1'b0;
		end else if (is_ds) begin
			if (cnt_tick) begin
				wave_r <= ds_hit && !(is_rtz && rtz_phase_r);
			end
		end else if (is_pwm && cnt_tick) begin
			if (hit_fall) begin
				wave_r <= 1'b0;
			end else if (hit_rise) begin
				wave_r <= 1'b1;
			end
		end else if (!is_pwm) begin
			wave_r <= 1'b0;
		end
	end

	assign o_wave_output    = wave_r && oe_r;
	assign o_wave_output_oe = oe_r;

	// match pulses and sticky flags, set wins over write-one clear
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_rise_match <= 1'b0;
			o_fall_match <= 1'b0;
		end else begin
			o_rise_match <= (cnt_tick && !is_ds && !is_capture && hit_rise) || cap_rise_store;
			o_fall_match <= cycle_end || cap_fall_store;
		end
	end
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			flag_rise_r <= 1'b0;
			flag_fall_r <= 1'b0;
		end else begin
			if (o_rise_match) begin
				flag_rise_r <= 1'b1;
			end else if (i_wr && i_addr == mmtc_pkg::OFF_STATUS && i_wdata[mmtc_pkg::STAT_RISE_BIT]) begin
				flag_rise_r <= 1'b0;
			end
			if (o_fall_match) begin
				flag_fall_r <= 1'b1;
			end else if (i_wr && i_addr == mmtc_pkg::OFF_STATUS && i_wdata[mmtc_pkg::STAT_FALL_BIT]) begin
				flag_fall_r <= 1'b0;
			end
		end
	end

	// read data, valid in the cycle after the read strobe
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			rdata_r <= 32'h00000000;
		end else if (i_rd) begin
			rdata_r <= 32'h00000000;
			case (i_addr)
				mmtc_pkg::OFF_CTRL: begin
					rdata_r[mmtc_pkg::CTRL_START_BIT]      <= running_r;
					rdata_r[mmtc_pkg::CTRL_MODE_LSB +: 3]  <= mode_r;
					rdata_r[mmtc_pkg::CTRL_SINGLE_BIT]     <= single_r;
					rdata_r[mmtc_pkg::CTRL_GATE_BIT]       <= gate_en_r;
					rdata_r[mmtc_pkg::CTRL_EDGE_LSB +: 2]  <= edge_r;
					rdata_r[mmtc_pkg::CTRL_OE_BIT]         <= oe_r;
					rdata_r[mmtc_pkg::CTRL_CLK32_BIT]      <= clk32_r;
				end
				mmtc_pkg::OFF_PRESC:  rdata_r[4:0]  <= presc_r;
				mmtc_pkg::OFF_RISE:   rdata_r[16:0] <= rise_r;
				mmtc_pkg::OFF_FALL:   rdata_r[16:0] <= fall_r;
				mmtc_pkg::OFF_STATUS: begin
					rdata_r[mmtc_pkg::STAT_RISE_BIT] <= flag_rise_r;
					rdata_r[mmtc_pkg::STAT_FALL_BIT] <= flag_fall_r;
					rdata_r[mmtc_pkg::STAT_RUN_BIT]  <= running_r;
					rdata_r[mmtc_pkg::STAT_WAVE_BIT] <= wave_r;
				end
				mmtc_pkg::OFF_COUNT:  rdata_r[16:0] <= cnt_r;
				default:              rdata_r <= 32'h00000000;
			endcase
		end
	end
	assign o_rdata = rdata_r;

endmodule

// >>> mmtc_pkg.sv
// constants shared by the multi-mode timer/counter
package mmtc_pkg;

	// register port
	localparam int unsigned ADDR_W      = 8;
	localparam int unsigned DATA_W      = 32;
	localparam logic [7:0]  OFF_CTRL    = 8'h00;
	localparam logic [7:0]  OFF_PRESC   = 8'h04;
	localparam logic [7:0]  OFF_RISE    = 8'h08;
	localparam logic [7:0]  OFF_FALL    = 8'h0C;
	localparam logic [7:0]  OFF_STATUS  = 8'h10;
	localparam logic [7:0]  OFF_COUNT   = 8'h14;

	// counter, compare registers and prescaler
	localparam int unsigned CNT_W       = 17;
	localparam int unsigned PRESC_W     = 5;
	localparam int unsigned DIV_W       = 16;
	localparam logic [4:0]  PRESC_MAX   = 5'h10;
	localparam logic [16:0] CNT_TOP     = 17'h1FFFF;
	localparam logic [16:0] CNT_RESET   = 17'h00000;

	// control register fields
	localparam int unsigned CTRL_START_BIT  = 0;
	localparam int unsigned CTRL_MODE_LSB   = 1;
	localparam int unsigned CTRL_SINGLE_BIT = 4;
	localparam int unsigned CTRL_GATE_BIT   = 5;
	localparam int unsigned CTRL_EDGE_LSB   = 6;
	localparam int unsigned CTRL_OE_BIT     = 8;
	localparam int unsigned CTRL_CLK32_BIT  = 9;

	// mode field encoding
	localparam logic [2:0] MODE_TIMER   = 3'h0;
	localparam logic [2:0] MODE_COUNTER = 3'h1;
	localparam logic [2:0] MODE_PWM     = 3'h2;
	localparam logic [2:0] MODE_CAPTURE = 3'h3;
	localparam logic [2:0] MODE_DS_NRZ  = 3'h4;
	localparam logic [2:0] MODE_DS_RTZ  = 3'h5;

	// event edge selection
	localparam logic [1:0] EDGE_RISE = 2'h0;
	localparam logic [1:0] EDGE_FALL = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h2;

	// status register fields
	localparam int unsigned STAT_RISE_BIT = 0;
	localparam int unsigned STAT_FALL_BIT = 1;
	localparam int unsigned STAT_RUN_BIT  = 2;
	localparam int unsigned STAT_WAVE_BIT = 3;

	// instance kinds
	localparam logic [1:0] KIND_TIMER_A = 2'h0;
	localparam logic [1:0] KIND_TIMER_B = 2'h1;
	localparam logic [1:0] KIND_PWM     = 2'h2;

	// pseudo-random scrambler for the delta-sigma pattern
	localparam logic [16:0] LFSR_SEED = 17'h00001;

endpackage

// >>> mmtc_monitor.sv
// concurrent checks on the timer/counter ports
`timescale 1ns/1ps
module mmtc_monitor (
	// clock and reset
	input wire logic        i_clk_sys,
	input wire logic        i_rstn,
	// register port
	input wire logic [7:0]  i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [31:0] o_rdata,
	// pins and events
	input wire logic        i_timer_a_clock_gate_input,
	input wire logic        i_capture_input,
	input wire logic        o_wave_output,
	input wire logic        o_wave_output_oe,
	input wire logic        o_rise_match,
	input wire logic        o_fall_match
);
	logic [2:0] mode_r;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);
	// mode as last written, so capture readbacks can be told apart
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn)
			mode_r <= 3'h0;
		else if (i_wr && i_addr == mmtc_pkg::OFF_CTRL)
			mode_r <= i_wdata[3:1];
	end
	AST_OE_GATE: assert property (o_wave_output |-> o_wave_output_oe)
		else $error("wave high without driver enable");
	AST_OE_WRITE: assert property (i_wr && i_addr == mmtc_pkg::OFF_CTRL |=> o_wave_output_oe == $past(i_wdata[8]))
		else $error("driver enable does not follow control write");
	AST_WAVE_CLEAR: assert property (i_wr && i_addr == mmtc_pkg::OFF_CTRL |=> !o_wave_output)
		else $error("wave not cleared on start or stop");
	AST_WIDTH: assert property (i_rd && (i_addr == mmtc_pkg::OFF_RISE || i_addr == mmtc_pkg::OFF_FALL
		|| i_addr == mmtc_pkg::OFF_COUNT) |=> o_rdata[31:17] == 15'h0000)
		else $error("count or compare value wider than 17 bits");
	AST_PRESC_CLAMP: assert property (i_wr && i_addr == mmtc_pkg::OFF_PRESC && i_wdata[4:0] > 5'h10
		##2 i_rd && i_addr == mmtc_pkg::OFF_PRESC |=> o_rdata == 32'h00000010)
		else $error("prescaler above 16 not held at 16");
	AST_PRESC_RB: assert property (i_wr && i_addr == mmtc_pkg::OFF_PRESC && i_wdata[4:0] <= 5'h10
		##2 i_rd && i_addr == mmtc_pkg::OFF_PRESC |=> o_rdata[4:0] == $past(i_wdata[4:0], 3))
		else $error("prescaler readback differs");
	AST_RISE_RB: assert property (mode_r != mmtc_pkg::MODE_CAPTURE && i_wr && i_addr == mmtc_pkg::OFF_RISE
		##2 i_rd && i_addr == mmtc_pkg::OFF_RISE |=> o_rdata[16:0] == $past(i_wdata[16:0], 3))
		else $error("rise readback differs");
	AST_CAP_STOP: assert property (mode_r == mmtc_pkg::MODE_CAPTURE && i_rd && i_addr == mmtc_pkg::OFF_RISE
		##2 i_rd && i_addr == mmtc_pkg::OFF_COUNT ##2 i_rd && i_addr == mmtc_pkg::OFF_COUNT
		|=> o_rdata == $past(o_rdata, 2))
		else $error("counter still runs after capture read");
	AST_FALL_FLAG: assert property (o_fall_match ##1 !(i_wr && i_addr == mmtc_pkg::OFF_STATUS) ##[0:1]
		(i_rd && i_addr == mmtc_pkg::OFF_STATUS) |=> o_rdata[1])
		else $error("fall event not flagged in status");
endmodule
bind multi_mode_timer_counter mmtc_monitor mmtc_monitor_inst (.i_clk_sys, .i_rstn, .i_addr, .i_wdata, .i_wr,
	.i_rd, .o_rdata, .i_timer_a_clock_gate_input, .i_capture_input, .o_wave_output, .o_wave_output_oe,
	.o_rise_match, .o_fall_match);

// >>> timer_pins_model.sv
// external event source and capture signal
`timescale 1ns/1ps
module timer_pins_model (
	// clock
	input wire logic i_clk_sys,
	// pins toward the timer
	output logic     o_gate,
	output logic     o_cap
);
	initial begin
		o_gate = 1'h0;
		o_cap = 1'h0;
	end
	task automatic set_gate(input logic lvl);
		@(posedge i_clk_sys);
		o_gate <= lvl;
	endtask
	// every level lasts 3 clocks, 150 ns
	task automatic pulse_gate(input int n);
		repeat (n) begin
			@(posedge i_clk_sys);
			o_gate <= 1'h1;
			repeat (3) @(posedge i_clk_sys);
			o_gate <= 1'h0;
			repeat (2) @(posedge i_clk_sys);
		end
	endtask
	task automatic pulse_cap(input int hi);
		@(posedge i_clk_sys);
		o_cap <= 1'h1;
		repeat (hi) @(posedge i_clk_sys);
		o_cap <= 1'h0;
		repeat (4) @(posedge i_clk_sys);
	endtask
endmodule

// >>> tb_top.sv
// self-checking bench for the timer/counter
`timescale 1ns/1ps
module tb_top;
	logic        clk;
	logic        rstn;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        wr;
	logic        rd;
	logic [31:0] rdata;
	logic        gate;
	logic        cap;
	logic        wave;
	logic        oe;
	logic        rise_m;
	logic        fall_m;
	logic [31:0] v;
	logic [31:0] c1;
	logic [31:0] c2;
	logic [31:0] f;
	logic [7:0]  offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
	int          errors;
	int          check_count;
	int          cyc;
	int          t0;
	int          t1;
	int          t2;
	int          h;
	int          run;
	int          rise_cnt;

	multi_mode_timer_counter #(.KIND(mmtc_pkg::KIND_TIMER_A)) multi_mode_timer_counter_inst (
		.i_clk_sys(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
		.i_timer_a_clock_gate_input(gate), .i_capture_input(cap), .o_wave_output(wave),
		.o_wave_output_oe(oe), .o_rise_match(rise_m), .o_fall_match(fall_m));
	timer_pins_model timer_pins_model_inst (.i_clk_sys(clk), .o_gate(gate), .o_cap(cap));

	always #25 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	always @(posedge clk) begin
		if (rise_m === 1'h1) rise_cnt <= rise_cnt + 1;
	end

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		#1 d = rdata;
	endtask
	task automatic wait_fall(output int t);
		t = -1;
		for (int i = 0; i < 400 && t < 0; i++) begin
			@(posedge clk);
			#1 if (fall_m === 1'h1) t = cyc;
		end
	endtask
	task automatic count_high(input int n, output int hi, output int mx);
		int r;
		hi = 0;
		mx = 0;
		r = 0;
		repeat (n) begin
			@(posedge clk);
			#1 r = (wave === 1'h1) ? r + 1 : 0;
			hi = hi + ((wave === 1'h1) ? 1 : 0);
			if (r > mx) mx = r;
		end
	endtask
	function automatic logic [31:0] ctl(input logic [2:0] m, input logic sgl, input logic gt, input logic [1:0] e,
		input logic en, input logic c32);
		return {22'h000000, c32, en, e, gt, sgl, m, 1'h1};
	endfunction
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		#(20000 * 50);
		errors++;
		wrap_up();
	end

	initial begin
		clk = 1'h0;
		rstn = 1'h0;
		addr = 8'h00;
		wdata = 32'h0;
		wr = 1'h0;
		rd = 1'h0;
		errors = 0;
		check_count = 0;
		cyc = 0;
		rise_cnt = 0;
		repeat (5) @(posedge clk);
		rstn <= 1'h1;
		foreach (offs[i]) begin
			rd_reg(offs[i], v);
			chk("reset value", v, 32'h0);
		end
		wr_reg(mmtc_pkg::OFF_PRESC, 32'h0000001F);
		rd_reg(mmtc_pkg::OFF_PRESC, v);
		chk("prescaler clamp", v, 32'h00000010);
		wr_reg(mmtc_pkg::OFF_PRESC, 32'h00000003);
		rd_reg(mmtc_pkg::OFF_PRESC, v);
		chk("prescaler", v, 32'h00000003);
		wr_reg(mmtc_pkg::OFF_RISE, 32'hFFFFFFFF);
		rd_reg(mmtc_pkg::OFF_RISE, v);
		chk("rise width", v, 32'h0001FFFF);
		// repeating timer over clock select and prescaler
		wr_reg(mmtc_pkg::OFF_FALL, 32'h9);
		for (int k = 0; k < 4; k++) begin
			wr_reg(mmtc_pkg::OFF_PRESC, k);
			wr_reg(mmtc_pkg::OFF_CTRL, ctl(mmtc_pkg::MODE_TIMER, 1'h0, 1'h0, 2'h0, 1'h0, !k[0]));
			wait_fall(t0);
			wait_fall(t1);
			chk("timer period", t1 - t0, 10 * (1 << k) * (k[0] ? 2 : 1));
		end
		wr_reg(mmtc_pkg::OFF_CTRL, 32'h0);
		wr_reg(mmtc_pkg::OFF_PRESC, 32'h0);
		wr_reg(mmtc_pkg::OFF_FALL, 32'h4);
		wr_reg(mmtc_pkg::OFF_STATUS, 32'h3);
		wr_reg(mmtc_pkg::OFF_CTRL, ctl(mmtc_pkg::MODE_TIMER, 1'h1, 1'h0, 2'h0, 1'h0, 1'h1));
		v = 32'h0;
		for (int i = 0; i < 20 && v[1] !== 1'h1; i++)
			rd_reg(mmtc_pkg::OFF_STATUS, v);
		chk("single shot flag", v[1], 1'h1);
		rd_reg(mmtc_pkg::OFF_STATUS, v);
		chk("single shot stopped", v[2], 1'h0);
		rd_reg(mmtc_pkg::OFF_COUNT, v);
		chk("single shot count", v, 32'h0);
		wr_reg(mmtc_pkg::OFF_STATUS, 32'h3);
		rd_reg(mmtc_pkg::OFF_STATUS, v);
		chk("flags cleared", v[1:0], 2'h0);
		// pwm: high for counts after rise up to fall, period fall+1
		wr_reg(mmtc_pkg::OFF_RISE, 32'h3);
		wr_reg(mmtc_pkg::OFF_FALL, 32'h7);
		wr_reg(mmtc_pkg::OFF_CTRL, ctl(mmtc_pkg::MODE_PWM, 1'h0, 1'h0, 2'h0, 1'h1, 1'h1));
		wait_fall(t0);
		t1 = rise_cnt;
		count_high(8, h, run);
		chk("pwm high", h, 32'h4);
		chk("rise pulses", rise_cnt - t1, 32'h1);
		wait_fall(t0);
		wr_reg(mmtc_pkg::OFF_FALL, 32'hB);
		wait_fall(t1);
		wait_fall(t2);
		chk("pwm old period", t1 - t0, 32'h8);
		chk("pwm new period", t2 - t1, 32'hC);
		count_high(12, h, run);
		chk("pwm new high", h, 32'h8);
		rd_reg(mmtc_pkg::OFF_STATUS, v);
		chk("match flags", v[1:0], 2'h3);
		wr_reg(mmtc_pkg::OFF_CTRL, ctl(mmtc_pkg::MODE_PWM, 1'h0, 1'h0, 2'h0, 1'h0, 1'h1));
		count_high(24, h, run);
		chk("pwm disabled", h, 32'h0);
		wr_reg(mmtc_pkg::OFF_CTRL, ctl(mmtc_pkg::MODE_PWM, 1'h1, 1'h0, 2'h0, 1'h1, 1'h1));
		count_high(40, h, run);
		chk("single pulse", h, 32'h8);
		// gating holds the counter while the pin is high
		wr_reg(mmtc_pkg::OFF_FALL, 32'h1FFFF);
		timer_pins_model_inst.set_gate(1'h1);
		repeat (3) @(posedge clk);
		wr_reg(mmtc_pkg::OFF_CTRL, ctl(mmtc_pkg::MODE_TIMER, 1'h0, 1'h1, 2'h0, 1'h0, 1'h1));
		repeat (6) @(posedge clk);
		rd_reg(mmtc_pkg::OFF_COUNT, v);
		chk("gated count", v, 32'h0);
		timer_pins_model_inst.set_gate(1'h0);
		repeat (6) @(posedge clk);
		rd_reg(mmtc_pkg::OFF_COUNT, v);
		chk("ungated count", v != 32'h0, 1'h1);
		for (int k = 0; k < 4; k++) begin
			wr_reg(mmtc_pkg::OFF_CTRL, ctl(mmtc_pkg::MODE_COUNTER, 1'h0, 1'h0, k[1:0], 1'h0, 1'h1));
			repeat (4) @(posedge clk);
			timer_pins_model_inst.pulse_gate(3);
			repeat (6) @(posedge clk);
			rd_reg(mmtc_pkg::OFF_COUNT, v);
			chk("event count", v, (k == 2) ? 32'h6 : (k == 3) ? 32'h0 : 32'h3);
		end
		// two pulses: only the second, 9 clocks wide, is kept
		wr_reg(mmtc_pkg::OFF_CTRL, ctl(mmtc_pkg::MODE_CAPTURE, 1'h0, 1'h0, 2'h0, 1'h0, 1'h1));
		repeat (4) @(posedge clk);
		timer_pins_model_inst.pulse_cap(5);
		timer_pins_model_inst.pulse_cap(9);
		repeat (4) @(posedge clk);
		rd_reg(mmtc_pkg::OFF_RISE, v);
		rd_reg(mmtc_pkg::OFF_COUNT, c1);
		rd_reg(mmtc_pkg::OFF_COUNT, c2);
		rd_reg(mmtc_pkg::OFF_FALL, f);
		chk("capture width", f - v, 32'h9);
		chk("capture origin", v > 32'hD, 1'h1);
		chk("capture stop", c2, c1);
		wr_reg(mmtc_pkg::OFF_RISE, 32'h0);
		wr_reg(mmtc_pkg::OFF_CTRL, ctl(mmtc_pkg::MODE_DS_NRZ, 1'h0, 1'h0, 2'h0, 1'h1, 1'h1));
		count_high(64, h, run);
		chk("ds zero", h, 32'h0);
		wr_reg(mmtc_pkg::OFF_RISE, 32'h1FFFF);
		wr_reg(mmtc_pkg::OFF_CTRL, ctl(mmtc_pkg::MODE_DS_NRZ, 1'h0, 1'h0, 2'h0, 1'h1, 1'h1));
		count_high(64, h, run);
		chk("ds full", h >= 62, 1'h1);
		wr_reg(mmtc_pkg::OFF_CTRL, ctl(mmtc_pkg::MODE_DS_RTZ, 1'h0, 1'h0, 2'h0, 1'h1, 1'h1));
		count_high(64, h, run);
		chk("rtz run", run, 32'h1);
		chk("rtz half", h >= 30 && h <= 32, 1'h1);
		wrap_up();
	end
endmodule
